//--- rtl/serial_port_buffer_status.sv
// Purpose: Buffer status flags, holding buffers and register map with
//          clear, set and invert aliases for a serial peripheral port.
// Assumes: Link pins come from outside clk_i and are synchronised here;
//          the link runs as a slave, mode 0, 32-bit words, MSB first.
// Notes:   Enhanced mode uses a four-entry buffer in each direction.
//
// What this block does
// - Transmit empty flag sets when a held word moves into the shifter.
// - Writing the data buffer clears the transmit empty flag.
// - Standard mode: writing the data buffer sets the transmit full flag.
// - Standard mode: moving the held word to the shifter clears it.
// - Transmit full one means the held word has not started yet.
// - Enhanced mode: transmit full exactly when cpu write pointer+1 = read.
// - Standard mode: receive full sets when a word lands in the buffer.
// - Standard mode: reading the data buffer clears receive full.
// - Enhanced mode: receive full exactly when port write pointer+1 = read.
// - Control, rate, control 2 and interrupt mask have clear/set/invert aliases.
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ps
module serial_port_buffer_status (
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone classic slave.
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [15:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Serial link.
    input  wire logic        sck_i,
    input  wire logic        sel_n_i,
    input  wire logic        sdi_i,
    output logic             sdo_o,
    output logic             sdo_oe_n_o,
    // Interrupt.
    output logic             irq_o
);

    // Bus request carrier and decode.
    spb_pkg::wb_req_t req;
    logic [15:0] base;
    logic [1:0]  kind;
    logic [31:0] lanes;
    logic        go;
    logic        wr_go;
    logic        rd_go;
    logic        hit_ctrl;
    logic        hit_flags;
    logic        hit_data;
    logic        hit_rate;
    logic        hit_ctrl2;
    logic        hit_ists;
    logic        hit_imsk;
    logic        buf_wr;
    logic        buf_rd;
    assign req       = '{cyc_i, stb_i, we_i, adr_i, sel_i, dat_i};
    assign base      = {req.adr[15:4], 4'h0};
    assign kind      = req.adr[3:2];
    assign lanes     = {{8{req.sel[3]}}, {8{req.sel[2]}},
                        {8{req.sel[1]}}, {8{req.sel[0]}}};
    assign go        = req.cyc && req.stb && !ack_o;
    assign wr_go     = go && req.we;
    assign rd_go     = go && !req.we;
    assign hit_ctrl  = base == spb_pkg::ADR_CTRL;
    assign hit_flags = base == spb_pkg::ADR_FLAGS;
    assign hit_data  = req.adr == spb_pkg::ADR_DATA;
    assign hit_rate  = base == spb_pkg::ADR_RATE;
    assign hit_ctrl2 = base == spb_pkg::ADR_CTRL2;
    assign hit_ists  = req.adr == spb_pkg::ADR_IRQ_STS;
    assign hit_imsk  = base == spb_pkg::ADR_IRQ_MSK;
    assign buf_wr    = wr_go && hit_data;
    assign buf_rd    = rd_go && hit_data;

    // Plain, clear, set or invert update of a register.
    function automatic logic [31:0] upd(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [1:0]  k,
                                        input logic [31:0] lm,
                                        input logic [31:0] wm);
        logic [31:0] b;
        logic [31:0] r;
        b = wd & lm;
        unique case (k)
            spb_pkg::KIND_PLAIN: r = (old & ~lm) | b;
            spb_pkg::KIND_CLR:   r = old & ~b;
            spb_pkg::KIND_SET:   r = old | b;
            spb_pkg::KIND_INV:   r = old ^ b;
        endcase
        upd = (old & ~wm) | (r & wm);
    endfunction

    // Software registers.
    logic [31:0] ctrl_q;
    logic [31:0] rate_q;
    logic [31:0] ctrl2_q;
    logic [31:0] imsk_q;
    logic        enh;
    logic        port_on;
    assign enh     = ctrl_q[spb_pkg::BIT_FIFO_SEL];
    assign port_on = ctrl_q[spb_pkg::BIT_ON];

    // Writes through the base address or any alias of it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q  <= spb_pkg::REG_RST;
            rate_q  <= spb_pkg::REG_RST;
            ctrl2_q <= spb_pkg::REG_RST;
            imsk_q  <= spb_pkg::REG_RST;
        end else if (wr_go) begin
            if (hit_ctrl)
                ctrl_q <= upd(ctrl_q, req.dat, kind, lanes,
                              spb_pkg::CTRL_WMASK);
            if (hit_rate)
                rate_q <= upd(rate_q, req.dat, kind, lanes,
                              spb_pkg::RATE_WMASK);
            if (hit_ctrl2)
                ctrl2_q <= upd(ctrl2_q, req.dat, kind, lanes,
                               spb_pkg::CTRL2_WMASK);
            if (hit_imsk)
                imsk_q <= upd(imsk_q, req.dat, kind, lanes,
                              spb_pkg::IRQ_WMASK);
        end
    end

    // Link pin synchronisers; only stage two and later feed logic.
    spb_pkg::link_t meta_q;
    spb_pkg::link_t sync_q;
    spb_pkg::link_t prev_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '{1'b0, 1'b1, 1'b0};
            sync_q <= '{1'b0, 1'b1, 1'b0};
            prev_q <= '{1'b0, 1'b1, 1'b0};
        end else begin
            meta_q <= '{sck_i, sel_n_i, sdi_i};
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Link edges, only while the port is on and selected.
    logic active;
    logic frame_go;
    logic sck_rise;
    logic sck_fall;
    assign active   = port_on && !sync_q.sel_n;
    assign frame_go = port_on && prev_q.sel_n && !sync_q.sel_n;
    assign sck_rise = active && !prev_q.sck && sync_q.sck;
    assign sck_fall = active && prev_q.sck && !sync_q.sck;

    // Transmit and receive storage with pointers.
    logic [31:0]      tx_mem_q [spb_pkg::DEPTH];
    logic [31:0]      rx_mem_q [spb_pkg::DEPTH];
    logic [1:0]       cpu_write_pointer_q;
    logic [1:0]       port_read_pointer_q;
    logic [1:0]       port_write_pointer_q;
    logic [1:0]       cpu_read_pointer_q;
    logic [1:0]       cw_next;
    logic [1:0]       sw_next;
    logic             tx_full_q;
    logic             tx_empty_q;
    logic             rx_full_q;
    logic             tx_full;
    logic             rx_full;
    logic             tx_avail;
    logic             rx_avail;
    logic [31:0]      shift_q;
    logic [4:0]       bit_cnt_q;
    logic             sdo_q;
    logic             word_end;
    logic             tx_move;
    logic             rx_done;
    logic [31:0]      rx_word;
    logic [31:0]      tx_word;
    assign cw_next  = cpu_write_pointer_q + 2'h1;
    assign sw_next  = port_write_pointer_q + 2'h1;
    // Full flags: standard mode is a single holding word per direction.
    assign tx_full  = enh ? (cw_next == port_read_pointer_q) : tx_full_q;
    assign rx_full  = enh ? (sw_next == cpu_read_pointer_q) : rx_full_q;
    assign tx_avail = enh ? (cpu_write_pointer_q != port_read_pointer_q) : tx_full_q;
    assign rx_avail = enh ? (port_write_pointer_q != cpu_read_pointer_q) : rx_full_q;
    assign word_end = sck_rise && bit_cnt_q == spb_pkg::LAST_BIT;
    // A held word, if any, is moved in at frame start and at every word boundary.
    assign tx_move  = (frame_go || word_end) && tx_avail;
    assign rx_done  = word_end;
    assign rx_word  = {shift_q[30:0], sync_q.sdi};
    assign tx_word  = tx_mem_q[port_read_pointer_q];

    // Buffer storage; standard mode always uses entry zero.
    always_ff @(posedge clk_i) begin
        if (buf_wr && !(enh && tx_full))
            tx_mem_q[cpu_write_pointer_q] <= upd(tx_mem_q[cpu_write_pointer_q], req.dat,
                                     spb_pkg::KIND_PLAIN, lanes,
                                     32'hFFFF_FFFF);
        if (rx_done && !(enh && rx_full))
            rx_mem_q[port_write_pointer_q] <= rx_word;
    end

    // Pointers advance only in enhanced mode and wrap by width.
    always_ff @(posedge clk_i) begin
        if (rst_i || !enh) begin
            cpu_write_pointer_q <= 2'h0;
            port_read_pointer_q <= 2'h0;
            port_write_pointer_q <= 2'h0;
            cpu_read_pointer_q <= 2'h0;
        end else begin
            if (buf_wr && !tx_full)
                cpu_write_pointer_q <= cw_next;
            if (tx_move)
                port_read_pointer_q <= port_read_pointer_q + 2'h1;
            if (rx_done && !rx_full)
                port_write_pointer_q <= sw_next;
            if (buf_rd && rx_avail)
                cpu_read_pointer_q <= cpu_read_pointer_q + 2'h1;
        end
    end

    // Hardware flags; a hardware set wins over a clear in the same cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_empty_q <= spb_pkg::FLAGS_RST[spb_pkg::BIT_TX_EMPTY];
            tx_full_q  <= spb_pkg::FLAGS_RST[spb_pkg::BIT_TX_FULL];
            rx_full_q  <= spb_pkg::FLAGS_RST[spb_pkg::BIT_RX_FULL];
        end else begin
            if (tx_move)
                tx_empty_q <= 1'b1;
            else if (buf_wr)
                tx_empty_q <= 1'b0;
            if (enh)
                tx_full_q <= 1'b0;
            else if (buf_wr)
                tx_full_q <= 1'b1;
            else if (tx_move)
                tx_full_q <= 1'b0;
            if (enh)
                rx_full_q <= 1'b0;
            else if (rx_done)
                rx_full_q <= 1'b1;
            else if (buf_rd)
                rx_full_q <= 1'b0;
        end
    end

    // Shift register: sample on rising clock, present on falling clock.
    always_ff @(posedge clk_i) begin
        if (rst_i || !active) begin
            shift_q   <= 32'h0000_0000;
            bit_cnt_q <= 5'h00;
            sdo_q     <= 1'b0;
        end else begin
            if (tx_move) begin
                shift_q <= tx_word;
                if (frame_go)
                    sdo_q <= tx_word[31];
            end else if (frame_go || word_end) begin
                shift_q <= 32'h0000_0000; // Nothing held: send zeros.
                if (frame_go)
                    sdo_q <= 1'b0;
            end else if (sck_rise) begin
                shift_q <= rx_word;
            end
            if (sck_rise)
                bit_cnt_q <= bit_cnt_q + 5'h01;
            if (sck_fall)
                sdo_q <= shift_q[31];
        end
    end
    assign sdo_o      = sdo_q;
    assign sdo_oe_n_o = !active;

    // Interrupt status, cleared by a read; a new event wins the race.
    logic [31:0] ists_q;
    logic [31:0] events;
    assign events = {30'h0, rx_done, tx_move};
    always_ff @(posedge clk_i) begin
        if (rst_i)
            ists_q <= spb_pkg::REG_RST;
        else if (rd_go && hit_ists)
            ists_q <= events;
        else
            ists_q <= ists_q | events;
    end
    assign irq_o = |(ists_q & imsk_q);

    // Read selection; unmapped addresses read as zero.
    logic [31:0] flags;
    logic [31:0] rd_mux;
    assign flags = {28'h0, tx_empty_q, 1'b0, tx_full, rx_full};
    assign rd_mux =
        hit_ctrl  ? ctrl_q  :
        hit_flags ? flags   :
        hit_data  ? rx_mem_q[cpu_read_pointer_q] :
        hit_rate  ? rate_q  :
        hit_ctrl2 ? ctrl2_q :
        hit_ists  ? ists_q  :
        hit_imsk  ? imsk_q  : 32'h0000_0000;

    // One-cycle answer; ack falls the cycle after it rose.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= go;
            if (rd_go)
                dat_o <= rd_mux;
        end
    end

    // Checks on the flag and register behaviour.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_ans;
        ack_o ##1 !ack_o;
    endsequence

    AST_ACK_ONE: assert property (s_req |=> s_ans)
        else $error("Bus answer not a single ack pulse.");
    AST_TBE_SET: assert property (tx_move |=> tx_empty_q)
        else $error("Transmit empty not set on move.");
    AST_TBE_CLR: assert property (buf_wr && !tx_move |=> !tx_empty_q)
        else $error("Transmit empty not cleared on write.");
    AST_TBF_SET: assert property (!enh && buf_wr ##1 !enh
                                  |-> tx_full)
        else $error("Transmit full not set on write.");
    AST_TBF_CLR: assert property (!enh && tx_move && !buf_wr ##1 !enh
                                  |-> !tx_full)
        else $error("Transmit full not cleared on move.");
    AST_TBF_ENH: assert property (enh |-> tx_full ==
                                  (cpu_write_pointer_q + 2'h1 == port_read_pointer_q))
        else $error("Enhanced transmit full mismatch.");
    AST_RBF_SET: assert property (!enh && rx_done ##1 !enh
                                  |-> rx_full)
        else $error("Receive full not set on word.");
    AST_RBF_CLR: assert property (!enh && buf_rd && !rx_done ##1 !enh
                                  |-> !rx_full)
        else $error("Receive full not cleared on read.");
    AST_RBF_ENH: assert property (enh |-> rx_full ==
                                  (port_write_pointer_q + 2'h1 == cpu_read_pointer_q))
        else $error("Enhanced receive full mismatch.");
    AST_ALIAS_SET: assert property (wr_go && hit_ctrl &&
                                    kind == spb_pkg::KIND_SET |=>
                                    ctrl_q == ($past(ctrl_q) |
                                    ($past(req.dat) & $past(lanes) &
                                    spb_pkg::CTRL_WMASK)))
        else $error("Set alias did not OR the written bits.");
    AST_STD_PTR: assert property (!enh |=> $past(!enh) |->
                                  cpu_write_pointer_q == 2'h0 && cpu_read_pointer_q == 2'h0)
        else $error("Pointers moved in standard mode.");

endmodule // serial_port_buffer_status

//--- inc/spb_pkg.sv
// Purpose: Shared constants and carrier types for the serial port buffer
//          status block.
// Assumes: Byte addresses on a 16-bit Wishbone address, 32-bit data.
// Notes:   Alias registers sit at base plus 0x4, 0x8 and 0xC.
package spb_pkg;

    // Bus and storage geometry.
    localparam int ADR_W  = 16;
    localparam int DATA_W = 32;
    localparam int DEPTH  = 4;
    localparam int PTR_W  = 2;
    localparam int CNT_W  = 5;

    // Register base addresses.
    localparam logic [15:0] ADR_CTRL    = 16'h8100;
    localparam logic [15:0] ADR_FLAGS   = 16'h8110;
    localparam logic [15:0] ADR_DATA    = 16'h8120;
    localparam logic [15:0] ADR_RATE    = 16'h8130;
    localparam logic [15:0] ADR_CTRL2   = 16'h8140;
    localparam logic [15:0] ADR_IRQ_STS = 16'h8150;
    localparam logic [15:0] ADR_IRQ_MSK = 16'h8160;

    // Access kind taken from address bits 3:2.
    localparam logic [1:0] KIND_PLAIN = 2'h0;
    localparam logic [1:0] KIND_CLR   = 2'h1;
    localparam logic [1:0] KIND_SET   = 2'h2;
    localparam logic [1:0] KIND_INV   = 2'h3;

    // Writable bits and reset values.
    localparam logic [31:0] CTRL_WMASK  = 32'hFF83_BFFF;
    localparam logic [31:0] RATE_WMASK  = 32'h0000_1FFF;
    localparam logic [31:0] CTRL2_WMASK = 32'h0000_9F8B;
    localparam logic [31:0] IRQ_WMASK   = 32'h0000_0003;
    localparam logic [31:0] REG_RST     = 32'h0000_0000;
    localparam logic [31:0] FLAGS_RST   = 32'h0000_0008;

    // Field positions.
    localparam int BIT_RX_FULL  = 0;
    localparam int BIT_TX_FULL  = 1;
    localparam int BIT_TX_EMPTY = 3;
    localparam int BIT_FIFO_SEL = 0;
    localparam int BIT_ON       = 15;
    localparam int EV_TX_MOVED  = 0;
    localparam int EV_RX_WORD   = 1;

    // Last bit index of a word on the link.
    localparam logic [CNT_W-1:0] LAST_BIT = 5'h1F;

    // One Wishbone request as seen by the slave.
    typedef struct packed {
        logic              cyc;
        logic              stb;
        logic              we;
        logic [ADR_W-1:0]  adr;
        logic [3:0]        sel;
        logic [DATA_W-1:0] dat;
    } wb_req_t;

    // Serial link pins sampled together.
    typedef struct packed {
        logic sck;
        logic sel_n;
        logic sdi;
    } link_t;

endpackage

//--- verification/link_master_model.sv
// Purpose: Link master that exchanges one 32-bit word per frame.
// Assumes: Mode 0, MSB first, link clock period 200 ns.
// Notes:   The link clock stands low between frames.
`timescale 1ns/1ps
module link_master_model (
    // Link pins toward the port.
    output spb_pkg::link_t pins_o,
    // Serial data back from the port.
    input  wire logic      sdo_i
);
    // Idle: deselected with the clock low.
    initial begin
        pins_o = '{1'b0, 1'b1, 1'b0};
    end

    // The port moves its output on the third bench clock edge after a falling
    // edge, so sampling on the rising edge leaves it the rest of the 100 ns low phase to settle.
    task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
        // Start a quarter period off the bench clock edge, so that no pin
        // moves in the time step in which the port samples it.
        #6.25;
        pins_o.sel_n = 1'b0;
        #200;
        for (int i = 31; i >= 0; i--) begin
            pins_o.sdi = tx[i];
            #100;
            pins_o.sck = 1'b1;
            rx[i] = sdo_i;
            #100;
            pins_o.sck = 1'b0;
        end
        #200;
        pins_o.sel_n = 1'b1;
        // The line has no pull, so show the inverse rather than stale data.
        pins_o.sdi = ~pins_o.sdi;
    endtask
endmodule // link_master_model

//--- verification/testbench.sv
// Purpose: Register, flag, alias and interrupt tests of the buffer block.
// Assumes: Wishbone answer time is not assumed; link master model on pins.
// Notes:   Both standard and pointer buffer modes are exercised.
`timescale 1ns/1ps
module testbench;
    localparam logic [31:0] W0 = 32'h1357_9BDF;
    localparam logic [31:0] W1 = 32'hA5C3_0F96;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;

    // Stimulus, observed outputs and counters.
    logic             clk_i;
    logic             rst_i;
    spb_pkg::wb_req_t req;
    spb_pkg::link_t   pins;
    logic [31:0]      dat_o;
    logic             ack_o;
    logic             sdo_o;
    logic             sdo_oe_n_o;
    logic             irq_o;
    logic [31:0]      q;
    logic [31:0]      rx;
    int               miscompares;
    int               checked;
    int               cycles;

    serial_port_buffer_status uut (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .cyc_i      (req.cyc),
        .stb_i      (req.stb),
        .we_i       (req.we),
        .adr_i      (req.adr),
        .sel_i      (req.sel),
        .dat_i      (req.dat),
        .dat_o      (dat_o),
        .ack_o      (ack_o),
        .sck_i      (pins.sck),
        .sel_n_i    (pins.sel_n),
        .sdi_i      (pins.sdi),
        .sdo_o      (sdo_o),
        .sdo_oe_n_o (sdo_oe_n_o),
        .irq_o      (irq_o)
    );

    link_master_model link (
        .pins_o (pins),
        .sdo_i  (sdo_o)
    );

    // Free-running 40 MHz clock.
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // A hang is cut short well after the expected run of under two thousand.
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            finish_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One classic cycle: held until ack is sampled high, then released.
    // The wait has no limit of its own; the cycle ceiling ends a hang.
    task automatic wb(input logic w, input logic [15:0] a,
                      input logic [3:0] s, input logic [31:0] d);
        @(posedge clk_i);
        req <= '{1'b1, 1'b1, w, a, s, d};
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        q = dat_o;
        req <= '0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        wb(1'b1, a, 4'hF, d);
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        wb(1'b0, a, 4'hF, 32'h0);
        check(q & m, e);
    endtask

    task automatic finish_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Main sequence: reset, registers, standard mode, then pointer mode.
    initial begin
        rst_i = 1'b1;
        req = '0;
        miscompares = 0;
        checked = 0;
        cycles = 0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        check({30'h0, irq_o, sdo_oe_n_o}, 32'h1);
        rd(spb_pkg::ADR_FLAGS, 32'h8, ALL);
        rd(spb_pkg::ADR_CTRL, 32'h0, ALL);
        rd(spb_pkg::ADR_CTRL2, 32'h0, ALL);
        // Byte lanes, then clear, set and invert aliases.
        wb(1'b1, spb_pkg::ADR_RATE, 4'h1, 32'h0000_1FFF);
        rd(spb_pkg::ADR_RATE, 32'hFF, ALL);
        wr(spb_pkg::ADR_RATE + 16'h4, 32'h0F);
        rd(spb_pkg::ADR_RATE, 32'hF0, ALL);
        wr(spb_pkg::ADR_RATE + 16'h8, 32'h1200);
        rd(spb_pkg::ADR_RATE, 32'h12F0, ALL);
        wr(spb_pkg::ADR_RATE + 16'hC, 32'h11);
        rd(spb_pkg::ADR_RATE, 32'h12E1, ALL);
        // The data buffer has no alias: this must not load a word.
        wr(spb_pkg::ADR_DATA + 16'h8, ALL);
        rd(spb_pkg::ADR_DATA + 16'h4, 32'h0, ALL);
        rd(spb_pkg::ADR_FLAGS, 32'h8, 32'hB);
        // Standard mode: one word each way.
        wr(spb_pkg::ADR_CTRL, 32'h8000);
        wr(spb_pkg::ADR_DATA, W0);
        rd(spb_pkg::ADR_FLAGS, 32'h2, 32'hB);
        // The output must be enabled while the frame is in progress.
        fork
            link.frame(W1, rx);
            begin
                repeat (20) @(posedge clk_i);
                check({31'h0, sdo_oe_n_o}, 32'h0);
            end
        join
        check(rx, W0);
        rd(spb_pkg::ADR_FLAGS, 32'h9, 32'hB);
        // Events stay pending while masked, then raise the line.
        check({31'h0, irq_o}, 32'h0);
        wr(spb_pkg::ADR_IRQ_MSK + 16'h8, 32'h3);
        repeat (2) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h1);
        rd(spb_pkg::ADR_IRQ_STS, 32'h3, ALL);
        repeat (2) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h0);
        rd(spb_pkg::ADR_DATA, W1, ALL);
        rd(spb_pkg::ADR_FLAGS, 32'h8, 32'hB);
        // Pointer mode: full means one slot short of the four entries.
        wr(spb_pkg::ADR_CTRL + 16'h8, 32'h1);
        rd(spb_pkg::ADR_CTRL, 32'h8001, ALL);
        for (int i = 0; i < 3; i++) begin
            wr(spb_pkg::ADR_DATA, W0 + 32'(i));
            rd(spb_pkg::ADR_FLAGS, {30'h0, i == 2, 1'b0}, 32'h3);
        end
        // A word boundary moves the next held word in even when the frame
        // then ends, so the second word is lost and the third frame finds
        // nothing held and sends zeros.
        for (int i = 0; i < 3; i++) begin
            link.frame(W1 + 32'(i), rx);
            check(rx, i == 2 ? 32'h0 : W0 + 32'(2 * i));
            rd(spb_pkg::ADR_FLAGS, {31'h0, i == 2}, 32'h3);
        end
        for (int i = 0; i < 3; i++) begin
            rd(spb_pkg::ADR_DATA, W1 + 32'(i), ALL);
            rd(spb_pkg::ADR_FLAGS, 32'h0, 32'h1);
        end
        // One more word each way wraps all four pointers back to zero.
        wr(spb_pkg::ADR_DATA, W0);
        rd(spb_pkg::ADR_FLAGS, 32'h0, 32'h2);
        link.frame(W1, rx);
        check(rx, W0);
        rd(spb_pkg::ADR_DATA, W1, ALL);
        rd(spb_pkg::ADR_FLAGS, 32'h8, 32'hB);
        finish_test();
    end
endmodule // testbench
